/* File: core/afm_pkg.sv */
package afm_pkg;
  localparam int NUM_CH = 4;
  localparam logic [6:0] ADDR_BASE = 7'h6C;
  localparam logic [7:0] REG_FAULT = 8'h00;
  localparam logic [7:0] REG_SUPPLY = 8'h01;
  localparam logic [7:0] REG_THERMAL = 8'h04;
  localparam logic [7:0] REG_GAIN = 8'h05;
  localparam logic [7:0] REG_INDSEL = 8'h0A;
  localparam logic [7:0] REG_HIZ = 8'h0C;
  localparam logic [7:0] REG_DCCFG = 8'h0D;
  localparam logic [7:0] REG_CTRL = 8'h0E;
  localparam int THERM_BIT0 = 5;
  localparam int SUP_UV_PWR = 0;
  localparam int SUP_UV_ANA = 1;
  localparam int SUP_UV_CP = 2;
  localparam int SUP_OV = 3;
  localparam int SUP_TSD = 4;
  localparam int FLT_OC0 = 0;
  localparam int FLT_DC0 = 4;
  localparam int CTRL_FRESET = 0;
  localparam int CTRL_DC_EN = 1;
  localparam int CTRL_EXT_OSC = 2;
  localparam logic [7:0] GAIN_RST = 8'hAA;
  localparam logic [7:0] INDSEL_RST = 8'h01;
  localparam logic [7:0] HIZ_RST = 8'h0F;
  localparam logic [7:0] DCCFG_RST = 8'h08;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] IND_CLIP = 2'h0;
  localparam logic [1:0] IND_WARN = 2'h1;
  localparam logic [1:0] IND_BOTH = 2'h2;
  localparam logic [1:0] IND_TWEET = 2'h3;
  localparam int CLK_MHZ = 200;
  localparam int OC_TRIP_US = 200;
  localparam int OC_TRIP_CYC = OC_TRIP_US * CLK_MHZ;
  localparam int DC_PERSIST_US = 100;
  localparam int DC_PERSIST_CYC = DC_PERSIST_US * CLK_MHZ;
  typedef struct packed {
    logic [NUM_CH-1:0] pulse_current_limit;
    logic [NUM_CH-1:0] peak_over;
    logic [NUM_CH-1:0] full_duty;
    logic [NUM_CH-1:0] tweet_over;
  } afm_chan_t;
  typedef struct packed {
    logic [2:0] thermal_warning;
    logic thermal_shutdown;
    logic uv_power;
    logic uv_analog;
    logic uv_charge_pump;
    logic overvoltage_event;
    logic power_on_reset;
  } afm_mon_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ = 5'b01000,
    ST_ACK = 5'b10000
  } afm_state_t;
endpackage : afm_pkg

/* File: core/afm_fault_monitor.sv */
`timescale 1ns/1ps
// Operation
// - pulse limit trims pulses, never shuts down
// - severe peak shuts only that channel
// - overcurrent shutdown flags fault, host restarts
// - dc offset compared, must persist
// - dc shutdown off at reset, per channel
// - clip asserted while full duty persists
// - shared indicator source select, four modes
// - indicator shows thermal warning after reset
// - three thermal thresholds in bits 5-7
// - thermal shutdown: hi-z, fault, port readable
// - warning holds until below level one
// - foldback reduces gain, audio continues
// - undervoltage flags fault and source bit
// - power-on reset releases control port
// - overvoltage flags fault and status bit
// - per-channel gain 12, 20, 26, 32 dB
// - host hi-z per channel, fault reset
// - strap picks osc role and address
// - switching clock synced or external
// - target only, no clock stretching
// - bytes msb first, device acks low
// - sequential access with auto-increment pointer
// - fault output active-low open drain
// - tweeter mode: low while current high
module afm_fault_monitor
  import afm_pkg::*;
#(
  parameter int OC_CYC = OC_TRIP_CYC,
  parameter int DC_CYC = DC_PERSIST_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_strap_in,
  input wire afm_chan_t chan_in,
  input wire logic [NUM_CH-1:0] dc_over_in,
  input wire afm_mon_t mon_in,
  input wire logic foldback_in,
  input wire logic oscillator_sync_line_in,
  input wire logic int_osc_in,
  output logic [NUM_CH-1:0] pulse_trim_out,
  output logic [NUM_CH-1:0] chan_hiz_out,
  output logic [NUM_CH*2-1:0] gain_out,
  output logic sw_clk_out,
  output logic osc_master_out,
  output logic [1:0] osc_role_out,
  output logic dc_level_out,
  output logic [7:0] dc_thresh_out,
  output logic fault_n_out,
  output logic fault_oe_out,
  output logic clip_warn_indicator_n_out,
  output logic clip_warn_oe_out
);
  if (OC_CYC < 1 || DC_CYC < 1) begin : g_bad_count
    $error("counts must be positive");
  end
  logic [2:0] scl_s_q, sda_s_q, osc_s_q, int_s_q;
  logic scl_q, sda_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      osc_s_q <= 3'h0;
      int_s_q <= 3'h0;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      osc_s_q <= {osc_s_q[1:0], oscillator_sync_line_in};
      int_s_q <= {int_s_q[1:0], int_osc_in};
    end
  end
  logic scl_d, sda_d;
  assign scl_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
  assign sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end
  logic start_c, stop_c, scl_rise, scl_fall;
  assign start_c = scl_q && scl_d && sda_q && !sda_d;
  assign stop_c = scl_q && scl_d && !sda_q && sda_d;
  assign scl_rise = !scl_q && scl_d;
  assign scl_fall = scl_q && !scl_d;
  // registers
  logic [7:0] gain_q, indsel_q, hiz_q, dccfg_q, ctrl_q, fault_q, supply_q;
  logic [7:0] ptr_q, sh_q, rd_q;
  logic [3:0] bitc_q;
  logic rw_q, ack_q, addr_ph_q, nack_q;
  afm_state_t st_q;
  logic [6:0] my_addr;
  assign my_addr = ADDR_BASE | {5'h00, addr_strap_in};
  logic wr_stb;
  logic [7:0] wr_data;
  logic fault_reset;
  assign fault_reset = wr_stb && ptr_q == REG_CTRL && wr_data[CTRL_FRESET];
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    unique case (a)
      REG_FAULT: rd_mux = fault_q;
      REG_SUPPLY: rd_mux = supply_q;
      REG_THERMAL: rd_mux = {mon_in.thermal_warning, 5'h00};
      REG_GAIN: rd_mux = gain_q;
      REG_INDSEL: rd_mux = indsel_q;
      REG_HIZ: rd_mux = hiz_q;
      REG_DCCFG: rd_mux = dccfg_q;
      REG_CTRL: rd_mux = ctrl_q;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux
  // bus engine; holds sda only low, never scl
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_IDLE;
      bitc_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      addr_ph_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (mon_in.power_on_reset || stop_c) begin
      st_q <= ST_IDLE;
      ack_q <= 1'b0;
    end else if (start_c) begin
      st_q <= ST_ADDR;
      bitc_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: ack_q <= 1'b0;
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_q};
            bitc_q <= bitc_q + 4'h1;
          end
          if (scl_fall && bitc_q == 4'h8) begin
            bitc_q <= 4'h0;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == my_addr) begin
                rw_q <= sh_q[0];
                ack_q <= 1'b1;
                addr_ph_q <= 1'b1;
                rd_q <= rd_mux(ptr_q);
                st_q <= ST_ACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end else begin
              ack_q <= 1'b1;
              st_q <= ST_ACK;
              if (addr_ph_q) begin
                ptr_q <= sh_q;
                addr_ph_q <= 1'b0;
              end else begin
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_rise && !ack_q) nack_q <= sda_q;
          if (scl_fall) begin
            ack_q <= 1'b0;
            if (!rw_q) begin
              st_q <= ST_WRITE;
            end else if (rw_q && ack_q) begin
              st_q <= ST_READ;
            end else if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              st_q <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bitc_q == 4'h7) begin
              bitc_q <= 4'h0;
              ptr_q <= ptr_q + 8'h01;
              rd_q <= rd_mux(ptr_q + 8'h01);
              st_q <= ST_ACK;
            end else begin
              bitc_q <= bitc_q + 4'h1;
              rd_q <= {rd_q[6:0], 1'b0};
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
  assign wr_stb = st_q == ST_WRITE && scl_fall && bitc_q == 4'h8 && !addr_ph_q;
  assign wr_data = sh_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe_out <= !mon_in.power_on_reset &&
        (ack_q || (st_q == ST_READ && !rd_q[7]));
    end
  end
  // host-writable configuration
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gain_q <= GAIN_RST;
      indsel_q <= INDSEL_RST;
      hiz_q <= HIZ_RST;
      dccfg_q <= DCCFG_RST;
      ctrl_q <= CTRL_RST;
    end else if (wr_stb) begin
      unique case (ptr_q)
        REG_GAIN: gain_q <= wr_data;
        REG_INDSEL: indsel_q <= wr_data;
        REG_HIZ: hiz_q <= wr_data;
        REG_DCCFG: dccfg_q <= wr_data;
        REG_CTRL: ctrl_q <= {wr_data[7:1], 1'b0};
        default: ;
      endcase
    end
  end
  // per-channel overcurrent and dc persistence timers
  logic [NUM_CH-1:0] oc_trip, dc_trip;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [31:0] oc_cnt_q, dc_cnt_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        oc_cnt_q <= 32'h0;
        dc_cnt_q <= 32'h0;
      end else begin
        oc_cnt_q <= chan_in.peak_over[c] ? oc_cnt_q + 32'h1 : 32'h0;
        dc_cnt_q <= dc_over_in[c] ? dc_cnt_q + 32'h1 : 32'h0;
      end
    end
    assign oc_trip[c] = chan_in.peak_over[c] && oc_cnt_q >= 32'(OC_CYC - 1);
    assign dc_trip[c] = dc_over_in[c] && dc_cnt_q >= 32'(DC_CYC - 1);
  end
  // latched faults: set wins over the reset command
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_q <= 8'h00;
      supply_q <= 8'h00;
    end else begin
      fault_q <= ((fault_reset ? 8'h00 : fault_q)
        | {4'h0, oc_trip} << FLT_OC0
        | ({4'h0, dc_trip & {NUM_CH{ctrl_q[CTRL_DC_EN]}}} << FLT_DC0));
      supply_q <= (fault_reset ? 8'h00 : supply_q) | {3'h0,
        mon_in.thermal_shutdown, mon_in.overvoltage_event,
        mon_in.uv_charge_pump, mon_in.uv_analog, mon_in.uv_power};
    end
  end
  logic glob_off;
  assign glob_off = |supply_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_hiz_out <= '1;
      pulse_trim_out <= '0;
      gain_out <= '0;
      fault_oe_out <= 1'b0;
    end else begin
      chan_hiz_out <= hiz_q[NUM_CH-1:0] | fault_q[FLT_OC0 +: NUM_CH]
        | fault_q[FLT_DC0 +: NUM_CH] | {NUM_CH{glob_off}};
      pulse_trim_out <= chan_in.pulse_current_limit;
      for (int i = 0; i < NUM_CH; i++) begin
        gain_out[2*i +: 2] <= (foldback_in && gain_q[2*i +: 2] != 2'h0) ?
          gain_q[2*i +: 2] - 2'h1 : gain_q[2*i +: 2];
      end
      fault_oe_out <= (|fault_q) || glob_off || mon_in.power_on_reset;
    end
  end
  assign fault_n_out = 1'b0;
  logic ind_act;
  always_comb begin
    unique case (indsel_q[1:0])
      IND_CLIP: ind_act = |chan_in.full_duty;
      IND_WARN: ind_act = mon_in.thermal_warning[0];
      IND_BOTH: ind_act = (|chan_in.full_duty) || mon_in.thermal_warning[0];
      IND_TWEET: ind_act = |chan_in.tweet_over;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) clip_warn_oe_out <= 1'b0;
    else clip_warn_oe_out <= ind_act;
  end
  assign clip_warn_indicator_n_out = 1'b0;
  // oscillator role and switching clock source
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_clk_out <= 1'b0;
      osc_master_out <= 1'b0;
      osc_role_out <= 2'h0;
    end else begin
      osc_role_out <= addr_strap_in;
      osc_master_out <= addr_strap_in == 2'h0;
      sw_clk_out <= (ctrl_q[CTRL_EXT_OSC] || addr_strap_in != 2'h0) ?
        ((osc_s_q[1] == osc_s_q[2]) ? osc_s_q[2] : sw_clk_out) :
        ((int_s_q[1] == int_s_q[2]) ? int_s_q[2] : sw_clk_out);
    end
  end
  assign dc_level_out = ctrl_q[CTRL_DC_EN];
  assign dc_thresh_out = dccfg_q;
endmodule : afm_fault_monitor

/* File: verification/afm_fault_monitor_properties.sv */
`timescale 1ns/1ps
module afm_fault_monitor_properties
  import afm_pkg::*;
#(
  parameter int OC_CYC = OC_TRIP_CYC,
  parameter int DC_CYC = DC_PERSIST_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_strap_in,
  input wire afm_chan_t chan_in,
  input wire afm_mon_t mon_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [NUM_CH-1:0] pulse_trim_out,
  input wire logic [NUM_CH-1:0] chan_hiz_out,
  input wire logic [1:0] osc_role_out,
  input wire logic osc_master_out,
  input wire logic fault_n_out,
  input wire logic fault_oe_out,
  input wire logic clip_warn_indicator_n_out
);
  int oc_cnt_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // consecutive cycles of peak overcurrent on channel 0
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) oc_cnt_q <= 0;
    else if (!chan_in.peak_over[0]) oc_cnt_q <= 0;
    else if (oc_cnt_q < OC_CYC + 16) oc_cnt_q <= oc_cnt_q + 1;
  trim_copy_a: assert property (pulse_trim_out == $past(chan_in.pulse_current_limit))
    else $error("pulse trim does not follow limit");
  oc_trip_a: assert property (oc_cnt_q > OC_CYC + 8 |-> chan_hiz_out[0])
    else $error("channel not shut on overcurrent");
  tsd_hiz_a: assert property (mon_in.thermal_shutdown |-> ##[1:4] (fault_oe_out && &chan_hiz_out))
    else $error("thermal shutdown not handled");
  uv_fault_a: assert property ((mon_in.uv_power || mon_in.uv_analog || mon_in.uv_charge_pump)
    |-> ##[1:4] fault_oe_out)
    else $error("undervoltage not flagged");
  ov_fault_a: assert property (mon_in.overvoltage_event |-> ##[1:4] fault_oe_out)
    else $error("overvoltage not flagged");
  por_release_a: assert property (mon_in.power_on_reset [*3] |=> !sda_oe_out)
    else $error("data line held during power-on reset");
  pins_low_a: assert property (!fault_n_out && !clip_warn_indicator_n_out)
    else $error("open-drain pin drives high");
  ack_low_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  strap_role_a: assert property ($stable(addr_strap_in) [*3] |->
    (osc_role_out == addr_strap_in && osc_master_out == (addr_strap_in == 2'h0)))
    else $error("oscillator role differs from strap");
endmodule : afm_fault_monitor_properties
bind afm_fault_monitor afm_fault_monitor_properties #(.OC_CYC(OC_CYC), .DC_CYC(DC_CYC)) i_props (.*);

/* File: verification/afm_bus_host.sv */
`timescale 1ns/1ps
module afm_bus_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // a quarter of the 80 ns bus clock period
  task automatic q();
    repeat (4) @(negedge clk_in);
  endtask : q
  task automatic start();
    scl_out = 1'b0;
    q();
    sda_pull_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_pull_out = 1'b1;
    q();
  endtask : start
  task automatic stop();
    scl_out = 1'b0;
    q();
    sda_pull_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_pull_out = 1'b0;
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    q();
    sda_pull_out = ~b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_in;
    q();
  endtask : bit_io
  // msb first, then the acknowledge bit (ack_out high releases the line)
  task automatic byte_io(input logic [7:0] d, input logic ack_out, output logic [7:0] r,
                         output logic ack_in);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_out, ack_in);
  endtask : byte_io
endmodule : afm_bus_host

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import afm_pkg::*;
  localparam int OC = 16;
  localparam logic [2:0] IND_EXP [4] = '{3'h2, 3'h1, 3'h3, 3'h4};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, pull, sda_w, sda_oe, sda_o, fault_oe, cw_oe;
  logic [1:0] strap = 2'h2;
  afm_chan_t chan = '0;
  logic [3:0] dc_over = 4'h0;
  afm_mon_t mon = '0;
  logic fb = 1'b0;
  logic osc = 1'b0;
  logic iosc = 1'b0;
  logic swc, dcl;
  logic [7:0] dct;
  logic [6:0] dev = 7'h6E;
  logic [3:0] hiz, trim;
  logic [7:0] gain;
  int n_fail = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  assign sda_w = !(pull || (sda_oe && !sda_o));
  afm_bus_host i_host (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_pull_out(pull));
  afm_fault_monitor #(.OC_CYC(OC), .DC_CYC(OC)) i_dut (
    .clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .addr_strap_in(strap), .chan_in(chan), .dc_over_in(dc_over),
    .mon_in(mon), .foldback_in(fb), .oscillator_sync_line_in(osc), .int_osc_in(iosc),
    .pulse_trim_out(trim), .chan_hiz_out(hiz), .gain_out(gain), .sw_clk_out(swc),
    .osc_master_out(), .osc_role_out(), .dc_level_out(dcl), .dc_thresh_out(dct),
    .fault_n_out(), .fault_oe_out(fault_oe), .clip_warn_indicator_n_out(),
    .clip_warn_oe_out(cw_oe));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic send(input logic [7:0] b, input logic [7:0] ack);
    logic [7:0] r;
    logic k;
    i_host.byte_io(b, 1'b1, r, k);
    chk("ack", {7'h0, k}, ack);
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
    i_host.start();
    send({dev, 1'b0}, 8'h00);
    send(a, 8'h00);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8], 8'h00);
    i_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, output logic [15:0] d);
    logic [7:0] r;
    logic k;
    i_host.start();
    send({dev, 1'b0}, 8'h00);
    send(a, 8'h00);
    i_host.start();
    send({dev, 1'b1}, 8'h00);
    for (int i = n - 1; i >= 0; i--) begin
      i_host.byte_io(8'hFF, i == 0, r, k);
      d[8*i +: 8] = r;
    end
    i_host.stop();
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [15:0] v;
    rd(a, 1, v);
    chk($sformatf("register %h", a), v[7:0], exp);
  endtask : rchk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
  initial begin
    logic [15:0] v;
    wait_n(16);
    rst_n = 1'b1;
    wait_n(4);
    chk("hiz", {4'h0, hiz}, HIZ_RST);
    chk("dc enable", {7'h0, dcl}, 8'h00);
    rchk(REG_GAIN, GAIN_RST);
    rchk(REG_INDSEL, INDSEL_RST);
    rchk(REG_CTRL, CTRL_RST);
    rchk(8'h02, 8'h00);
    mon.thermal_warning = 3'h7;
    rchk(REG_THERMAL, 8'hE0);
    chk("indicator", {7'h0, cw_oe}, 8'h01);
    mon.thermal_warning = 3'h1;
    rchk(REG_THERMAL, 8'h20);
    chk("indicator", {7'h0, cw_oe}, 8'h01);
    wr(REG_HIZ, 16'h0010, 2);
    rd(REG_HIZ, 2, v);
    chk("sequential", v[15:8], 8'h00);
    chk("sequential", v[7:0], 8'h10);
    chk("threshold", dct, 8'h10);
    for (int m = 0; m < 4; m++) begin
      wr(REG_INDSEL, 16'(m), 1);
      for (int s = 0; s < 3; s++) begin
        mon.thermal_warning[0] = (s == 0);
        chan.full_duty[2] = (s == 1);
        chan.tweet_over[2] = (s == 2);
        wait_n(8);
        chk("indicator", {7'h0, cw_oe}, {7'h0, IND_EXP[m][s]});
      end
    end
    chan = '0;
    mon = '0;
    wr(REG_GAIN, 16'h00FA, 1);
    wait_n(4);
    chk("gain", gain, 8'hFA);
    fb = 1'b1;
    wait_n(4);
    chk("gain", gain, 8'hA5);
    chk("hiz", {4'h0, hiz}, 8'h00);
    fb = 1'b0;
    chan.pulse_current_limit = 4'hF;
    chan.peak_over[0] = 1'b1;
    wait_n(OC / 2);
    chk("trim", {4'h0, trim}, 8'h0F);
    chk("hiz", {4'h0, hiz}, 8'h00);
    wait_n(2 * OC);
    chk("hiz", {4'h0, hiz}, 8'h01);
    chk("fault", {7'h0, fault_oe}, 8'h01);
    chan = '0;
    dc_over = 4'h8;
    wait_n(2 * OC);
    chk("hiz", {4'h0, hiz}, 8'h01);
    dc_over = 4'h0;
    rchk(REG_FAULT, 8'h01);
    wr(REG_CTRL, 16'h0003, 1);
    chk("dc enable", {7'h0, dcl}, 8'h01);
    wr(REG_HIZ, 16'h0000, 1);
    chk("hiz", {4'h0, hiz}, 8'h00);
    chk("fault", {7'h0, fault_oe}, 8'h00);
    rchk(REG_FAULT, 8'h00);
    dc_over = 4'h8;
    wait_n(2 * OC);
    chk("hiz", {4'h0, hiz}, 8'h08);
    chk("fault", {7'h0, fault_oe}, 8'h01);
    dc_over = 4'h0;
    rchk(REG_FAULT, 8'h80);
    mon.uv_analog = 1'b1;
    mon.overvoltage_event = 1'b1;
    wait_n(4);
    mon = '0;
    mon.thermal_shutdown = 1'b1;
    wait_n(4);
    chk("hiz", {4'h0, hiz}, 8'h0F);
    rchk(REG_SUPPLY, 8'h1A);
    mon = '0;
    wr(REG_CTRL, 16'h0003, 1);
    rchk(REG_SUPPLY, 8'h00);
    mon.uv_power = 1'b1;
    mon.uv_charge_pump = 1'b1;
    wait_n(4);
    mon = '0;
    chk("fault", {7'h0, fault_oe}, 8'h01);
    rchk(REG_SUPPLY, 8'h05);
    wr(REG_CTRL, 16'h0003, 1);
    i_host.start();
    send({7'h6C, 1'b0}, 8'h01);
    i_host.stop();
    mon.power_on_reset = 1'b1;
    i_host.start();
    send({7'h6E, 1'b0}, 8'h01);
    i_host.stop();
    mon = '0;
    osc = 1'b1;
    wait_n(6);
    chk("switching clock", {7'h0, swc}, 8'h01);
    osc = 1'b0;
    iosc = 1'b1;
    wait_n(6);
    chk("switching clock", {7'h0, swc}, 8'h00);
    strap = 2'h0;
    dev = 7'h6C;
    wait_n(6);
    chk("switching clock", {7'h0, swc}, 8'h01);
    wr(REG_CTRL, 16'h0004, 1);
    chk("switching clock", {7'h0, swc}, 8'h00);
    conclude();
  end
endmodule : testbench
